// ==== common/slpfc_pkg.sv ====
// Constants for the serial-link PLL and framing configuration bank.
// Assumes an 8-bit register file behind a 3-wire serial port, 15-bit address.
package slpfc_pkg;
    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [14:0] ADDR_RATE_SELECT = 15'h056e;
    localparam logic [14:0] ADDR_LOCK_FLAG = 15'h056f;
    localparam logic [14:0] ADDR_FRAME_SIZING = 15'h0570;
    localparam logic [14:0] ADDR_LINK_CTRL_ONE = 15'h0571;
    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int RATE_MSB = 7;
    localparam int RATE_LSB = 4;
    localparam int LOCK_BIT = 7;
    localparam int LANES_MSB = 7;
    localparam int LANES_LSB = 6;
    localparam int CONV_MSB = 5;
    localparam int CONV_LSB = 3;
    localparam int OCTS_MSB = 2;
    localparam int OCTS_LSB = 0;
    localparam int STBY_BIT = 7;
    localparam int TAIL_PN_BIT = 6;
    localparam int LONG_TEST_BIT = 5;
    localparam logic [3:0] RATE_RESET = 4'h0;
    localparam logic [1:0] LANES_RESET = 2'h1;
    localparam logic [2:0] CONV_RESET = 3'h1;
    localparam logic [2:0] OCTS_RESET = 3'h1;
    // ************************************************************
    // Lane-rate range codes
    // ************************************************************
    localparam logic [3:0] RATE_6G75_13G5 = 4'h0;
    localparam logic [3:0] RATE_3G375_6G75 = 4'h1;
    localparam logic [3:0] RATE_13G5_15G = 4'h3;
    localparam logic [3:0] RATE_1G6875_3G375 = 4'h5;
    // ************************************************************
    // Serial port framing and link characters
    // ************************************************************
    localparam logic [4:0] SPI_INSTR_LAST = 5'h0f;
    localparam logic [4:0] SPI_DATA_FIRST = 5'h10;
    localparam logic [4:0] SPI_DATA_LAST = 5'h17;
    localparam logic [7:0] K28_5_OCTET = 8'hbc;
    localparam logic [7:0] STBY_OCTET = 8'h00;
    typedef enum logic [2:0] {
        SPI_IDLE = 3'b001,
        SPI_INSTR = 3'b010,
        SPI_DATA = 3'b100
    } slpfc_spi_e;
endpackage

// ==== core/slpfc_regs.sv ====
// Configuration and status bank for the serial transmit link, plus the
// octet selector that applies standby and test-sample behaviour.
// Assumes serial port pins and lock/standby levels are asynchronous to clk_sys.
`timescale 1ns/10ps
module slpfc_regs
    import slpfc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Serial port pins
    input wire logic spi_csb_n,
    input wire logic spi_sclk,
    input wire logic spi_sdio_in,
    output logic spi_sdio_out,
    output logic spi_sdio_oe_n,
    // Status from analog side and standby pin
    input wire logic pll_locked,
    input wire logic standby_pin,
    // Sample stream in
    input wire logic [7:0] sample_octet,
    // Configuration out
    output logic [3:0] lane_rate_code,
    output logic lane_rate_legal,
    output logic [3:0] lane_count,
    output logic [7:0] converter_count,
    output logic [7:0] frame_octets,
    output logic tail_pn_enable,
    // Link octet out
    output logic [7:0] tx_octet,
    output logic tx_is_k
);
    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic sclk_prev;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync1 <= 5'h01;
            sync2 <= 5'h01;
            sclk_prev <= 1'b0;
        end else begin
            sync1 <= {standby_pin, pll_locked, spi_sdio_in, spi_sclk, spi_csb_n};
            sync2 <= sync1;
            sclk_prev <= sync2[1];
        end
    end
    logic csb_n_s;
    logic sclk_rise;
    logic sclk_fall;
    logic sdi_s;
    logic lock_s;
    logic stby_s;
    assign csb_n_s = sync2[0];
    assign sclk_rise = sync2[1] & ~sclk_prev;
    assign sclk_fall = ~sync2[1] & sclk_prev;
    assign sdi_s = sync2[2];
    assign lock_s = sync2[3];
    assign stby_s = sync2[4];

    // ************************************************************
    // Serial port slave
    // ************************************************************
    slpfc_spi_e spi_state;
    logic [4:0] bit_cnt;
    logic [15:0] shift_in;
    logic [14:0] acc_addr;
    logic acc_read;
    logic [7:0] rd_buf;
    logic wr_pulse;
    logic [7:0] wr_data;
    logic [7:0] rd_mux;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            spi_state <= SPI_IDLE;
            bit_cnt <= 5'h00;
            shift_in <= 16'h0000;
            acc_addr <= 15'h0000;
            acc_read <= 1'b0;
            rd_buf <= 8'h00;
            wr_pulse <= 1'b0;
            wr_data <= 8'h00;
        end else begin
            wr_pulse <= 1'b0;
            if (csb_n_s) begin
                spi_state <= SPI_IDLE;
                bit_cnt <= 5'h00;
            end else if (sclk_rise) begin
                shift_in <= {shift_in[14:0], sdi_s};
                bit_cnt <= bit_cnt + 5'h01;
                unique case (spi_state)
                    SPI_IDLE, SPI_INSTR: begin
                        spi_state <= SPI_INSTR;
                        if (bit_cnt == SPI_INSTR_LAST) begin
                            spi_state <= SPI_DATA;
                            acc_read <= shift_in[14];
                            acc_addr <= {shift_in[13:0], sdi_s};
                        end
                    end
                    SPI_DATA: begin
                        if (bit_cnt == SPI_DATA_LAST) begin
                            spi_state <= SPI_IDLE;
                            wr_pulse <= ~acc_read;
                            wr_data <= {shift_in[6:0], sdi_s};
                        end
                    end
                endcase
            end
            if (spi_state == SPI_DATA && bit_cnt == SPI_DATA_FIRST) begin
                rd_buf <= rd_mux;
            end
        end
    end

    // Read data leaves on falling clock edges during the data phase
    logic [4:0] out_idx;
    assign out_idx = SPI_DATA_LAST - bit_cnt;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            spi_sdio_out <= 1'b0;
            spi_sdio_oe_n <= 1'b1;
        end else if (csb_n_s || !acc_read || spi_state != SPI_DATA) begin
            spi_sdio_oe_n <= 1'b1;
        end else if (sclk_fall) begin
            spi_sdio_oe_n <= 1'b0;
            spi_sdio_out <= rd_buf[out_idx[2:0]];
        end
    end

    // ************************************************************
    // Register file
    // ************************************************************
    logic [3:0] rate_field;
    logic [1:0] lanes_field;
    logic [2:0] conv_field;
    logic [2:0] octs_field;
    logic stby_k_mode;
    logic long_test;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rate_field <= RATE_RESET;
            lanes_field <= LANES_RESET;
            conv_field <= CONV_RESET;
            octs_field <= OCTS_RESET;
            stby_k_mode <= 1'b0;
            tail_pn_enable <= 1'b0;
            long_test <= 1'b0;
        end else if (wr_pulse) begin
            unique case (acc_addr)
                ADDR_RATE_SELECT: rate_field <= wr_data[RATE_MSB:RATE_LSB];
                ADDR_FRAME_SIZING: begin
                    lanes_field <= wr_data[LANES_MSB:LANES_LSB];
                    conv_field <= wr_data[CONV_MSB:CONV_LSB];
                    octs_field <= wr_data[OCTS_MSB:OCTS_LSB];
                end
                ADDR_LINK_CTRL_ONE: begin
                    stby_k_mode <= wr_data[STBY_BIT];
                    tail_pn_enable <= wr_data[TAIL_PN_BIT];
                    long_test <= wr_data[LONG_TEST_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        rd_mux = 8'h00;
        unique case (acc_addr)
            ADDR_RATE_SELECT: rd_mux[RATE_MSB:RATE_LSB] = rate_field;
            ADDR_LOCK_FLAG: rd_mux[LOCK_BIT] = lock_s;
            ADDR_FRAME_SIZING: rd_mux = {lanes_field, conv_field, octs_field};
            ADDR_LINK_CTRL_ONE: begin
                rd_mux[STBY_BIT] = stby_k_mode;
                rd_mux[TAIL_PN_BIT] = tail_pn_enable;
                rd_mux[LONG_TEST_BIT] = long_test;
            end
            default: rd_mux = 8'h00;
        endcase
    end

    // ************************************************************
    // Decoded configuration
    // ************************************************************
    // rate range decode
    assign lane_rate_code = rate_field;
    assign lane_rate_legal = (rate_field == RATE_6G75_13G5) || (rate_field == RATE_3G375_6G75)
        || (rate_field == RATE_13G5_15G) || (rate_field == RATE_1G6875_3G375);
    assign lane_count = 4'h1 << lanes_field;
    assign converter_count = 8'h01 << conv_field;
    assign frame_octets = 8'h01 << octs_field;

    // ************************************************************
    // Octet selector
    // ************************************************************
    logic [7:0] octet_idx;
    logic [3:0] frame_idx;
    always_ff @(posedge clk_sys) begin
        if (rst || !long_test) begin
            octet_idx <= 8'h00;
            frame_idx <= 4'h0;
        end else if (octet_idx == frame_octets - 8'h01) begin
            octet_idx <= 8'h00;
            frame_idx <= frame_idx + 4'h1;
        end else begin
            octet_idx <= octet_idx + 8'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tx_octet <= STBY_OCTET;
            tx_is_k <= 1'b0;
        end else if (stby_s) begin
            tx_octet <= stby_k_mode ? K28_5_OCTET : STBY_OCTET;
            tx_is_k <= stby_k_mode;
        end else if (long_test) begin
            tx_octet <= {frame_idx, octet_idx[3:0]};
            tx_is_k <= 1'b0;
        end else begin
            tx_octet <= sample_octet;
            tx_is_k <= 1'b0;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence write_link_one;
        wr_pulse && acc_addr == ADDR_LINK_CTRL_ONE;
    endsequence
    sequence write_sizing;
        wr_pulse && acc_addr == ADDR_FRAME_SIZING;
    endsequence
    sequence test_wrap_seen;
        long_test && !stby_s && octet_idx == frame_octets - 8'h01 ##1 long_test;
    endsequence

    chk_rate_legal: assert property (
        lane_rate_legal == (rate_field inside {4'h0, 4'h1, 4'h3, 4'h5}))
        else $error("rate legality wrong");
    chk_rate_low_zero: assert property (acc_addr == ADDR_RATE_SELECT |-> rd_mux[3:0] == 4'h0)
        else $error("rate low nibble not zero");
    chk_lanes_write: assert property (write_sizing |=>
        lane_count == (4'h1 << $past(wr_data[7:6])))
        else $error("lane count not updated");
    chk_conv_write: assert property (write_sizing |=>
        converter_count == (8'h01 << $past(wr_data[5:3])))
        else $error("converter count not updated");
    chk_octs_write: assert property (write_sizing |=>
        frame_octets == (8'h01 << $past(wr_data[2:0])))
        else $error("octet count not updated");
    chk_stby_k_out: assert property (stby_s && stby_k_mode |=> tx_octet == 8'hbc && tx_is_k)
        else $error("standby K28.5 missing");
    chk_stby_zero_out: assert property (stby_s && !stby_k_mode |=>
        tx_octet == 8'h00 && !tx_is_k)
        else $error("standby zeros missing");
    chk_long_write: assert property (write_link_one |=> long_test == $past(wr_data[5]))
        else $error("long test bit not stored");
    chk_test_wrap: assert property (test_wrap_seen |->
        octet_idx == 8'h00 && frame_idx == $past(frame_idx) + 4'h1)
        else $error("test frame did not wrap");
    chk_read_drive: assert property (spi_state == SPI_DATA && !acc_read |-> spi_sdio_oe_n)
        else $error("pin driven during write");
endmodule

// ==== test/slpfc_rx_model.sv ====
// Receiver model for the link octet stream: tracks sync runs and data octets.
// Assumes one octet per clk_sys cycle on tx_octet with tx_is_k beside it.
`timescale 1ns/10ps
module slpfc_rx_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Link octets
    input wire logic [7:0] tx_octet,
    input wire logic tx_is_k,
    // Observations
    output logic [7:0] k_run,
    output logic [7:0] last_data
);
    // ****
    // Sync character run, saturating
    // ****
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            k_run <= 8'h00;
        end else if (tx_is_k && tx_octet == 8'hbc) begin
            k_run <= (k_run == 8'hff) ? k_run : k_run + 8'h01;
        end else begin
            k_run <= 8'h00;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            last_data <= 8'h00;
        end else if (!tx_is_k) begin
            last_data <= tx_octet;
        end
    end
endmodule

// ==== test/slpfc_regs_tb_top.sv ====
// Self-checking bench for the link configuration bank and octet selector.
// Assumes registers are reached only through the 3-wire serial port.
`timescale 1ns/10ps
module slpfc_regs_tb_top;
    import slpfc_pkg::*;
    logic clk_sys, rst, spi_csb_n, spi_sclk, spi_sdio_in, pll_locked, standby_pin;
    logic spi_sdio_out, spi_sdio_oe_n, lane_rate_legal, tail_pn_enable, tx_is_k;
    logic [7:0] sample_octet, converter_count, frame_octets, tx_octet, k_run, last_data, rd;
    logic [3:0] lane_rate_code, lane_count;
    int failures = 0;
    int tests_run = 0;
    slpfc_regs dut_u (.clk_sys(clk_sys), .rst(rst), .spi_csb_n(spi_csb_n), .spi_sclk(spi_sclk),
        .spi_sdio_in(spi_sdio_in), .spi_sdio_out(spi_sdio_out), .spi_sdio_oe_n(spi_sdio_oe_n),
        .pll_locked(pll_locked), .standby_pin(standby_pin), .sample_octet(sample_octet),
        .lane_rate_code(lane_rate_code), .lane_rate_legal(lane_rate_legal),
        .lane_count(lane_count), .converter_count(converter_count),
        .frame_octets(frame_octets), .tail_pn_enable(tail_pn_enable),
        .tx_octet(tx_octet), .tx_is_k(tx_is_k));
    slpfc_rx_model rx_u (.clk_sys(clk_sys), .rst(rst), .tx_octet(tx_octet),
        .tx_is_k(tx_is_k), .k_run(k_run), .last_data(last_data));
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // ****
    // Shared tasks
    // ****
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // One frame: direction bit, 15 address bits, 8 data bits, MSB first
    task automatic spi(input logic rw, input logic [14:0] a, input logic [7:0] wd);
        logic [23:0] f;
        f = {rw, a, wd};
        spi_csb_n = 1'b0;
        cyc(2);
        for (int i = 23; i >= 0; i--) begin
            spi_sdio_in = f[i];
            cyc(6);
            if (i < 8) begin
                rd[i] = spi_sdio_out;
            end
            if (i == 0 && rw) begin
                chk(8'(spi_sdio_oe_n), 8'h00);
            end
            spi_sclk = 1'b1;
            cyc(6);
            spi_sclk = 1'b0;
        end
        spi_csb_n = 1'b1;
        cyc(5);
        chk(8'(spi_sdio_oe_n), 8'h01);
    endtask
    task automatic rd_chk(input logic [14:0] a, input logic [7:0] exp);
        spi(1'b1, a, 8'h00);
        chk(rd, exp);
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_reset();
        rd_chk(ADDR_RATE_SELECT, 8'h00);
        rd_chk(ADDR_FRAME_SIZING, 8'h49);
        rd_chk(ADDR_LINK_CTRL_ONE, 8'h00);
        chk({4'h0, lane_count}, 8'h02);
        chk(converter_count, 8'h02);
        chk(frame_octets, 8'h02);
    endtask
    task automatic t_rate();
        logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h3, 4'h5, 4'h2};
        for (int i = 0; i < 5; i++) begin
            spi(1'b0, ADDR_RATE_SELECT, {codes[i], 4'hf});
            rd_chk(ADDR_RATE_SELECT, {codes[i], 4'h0});
            chk({4'h0, lane_rate_code}, {4'h0, codes[i]});
            chk(8'(lane_rate_legal), 8'(i < 4));
        end
    endtask
    task automatic t_size();
        logic [7:0] v [3] = '{8'h13, 8'h40, 8'h49};
        for (int i = 0; i < 3; i++) begin
            spi(1'b0, ADDR_FRAME_SIZING, v[i]);
            rd_chk(ADDR_FRAME_SIZING, v[i]);
            chk({4'h0, lane_count}, 8'h01 << v[i][7:6]);
            chk(converter_count, 8'h01 << v[i][5:3]);
            chk(frame_octets, 8'h01 << v[i][2:0]);
        end
    endtask
    task automatic t_lock();
        rd_chk(ADDR_LOCK_FLAG, 8'h00);
        pll_locked = 1'b1;
        spi(1'b0, ADDR_LOCK_FLAG, 8'h7f);
        rd = 8'h00;
        for (int n = 0; n < 4 && rd[7] !== 1'b1; n++) begin
            spi(1'b1, ADDR_LOCK_FLAG, 8'h00);
        end
        chk(rd, 8'h80);
        spi(1'b0, 15'h0572, 8'hff);
        rd_chk(15'h0572, 8'h00);
    endtask
    task automatic t_link();
        sample_octet = 8'h5a;
        spi(1'b0, ADDR_LINK_CTRL_ONE, 8'hff);
        rd_chk(ADDR_LINK_CTRL_ONE, 8'he0);
        chk(8'(tail_pn_enable), 8'h01);
        standby_pin = 1'b1;
        cyc(6);
        chk(tx_octet, 8'hbc);
        chk(8'(tx_is_k), 8'h01);
        chk(k_run, 8'h03);
        spi(1'b0, ADDR_LINK_CTRL_ONE, 8'h00);
        chk(8'(tail_pn_enable), 8'h00);
        cyc(2);
        chk(tx_octet, 8'h00);
        chk(8'(tx_is_k), 8'h00);
        standby_pin = 1'b0;
        cyc(5);
        chk(last_data, 8'h5a);
    endtask
    task automatic t_long();
        logic [7:0] p;
        sample_octet = 8'hee;
        spi(1'b0, ADDR_FRAME_SIZING, 8'h49);
        spi(1'b0, ADDR_LINK_CTRL_ONE, 8'h20);
        cyc(3);
        p = tx_octet;
        for (int i = 0; i < 12; i++) begin
            cyc(1);
            chk(tx_octet, p[0] ? {p[7:4] + 4'h1, 4'h0} : {p[7:4], 4'h1});
            p = tx_octet;
        end
        spi(1'b0, ADDR_LINK_CTRL_ONE, 8'h00);
        cyc(2);
        chk(tx_octet, 8'hee);
    endtask
    task automatic t_rerst();
        spi(1'b0, ADDR_FRAME_SIZING, 8'h13);
        spi(1'b0, ADDR_RATE_SELECT, 8'h30);
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        cyc(3);
        chk(8'(spi_sdio_oe_n), 8'h01);
        chk({4'h0, lane_count}, 8'h02);
        chk(frame_octets, 8'h02);
        rd_chk(ADDR_FRAME_SIZING, 8'h49);
        rd_chk(ADDR_RATE_SELECT, 8'h00);
    endtask
    initial begin
        rst = 1'b1;
        spi_csb_n = 1'b1;
        spi_sclk = 1'b0;
        spi_sdio_in = 1'b0;
        pll_locked = 1'b0;
        standby_pin = 1'b0;
        sample_octet = 8'h00;
        rd = 8'h00;
        cyc(2);
        rst = 1'b0;
        cyc(3);
        t_reset();
        t_rate();
        t_size();
        t_lock();
        t_link();
        t_long();
        t_rerst();
        end_of_test();
    end
    initial begin
        repeat (100000) @(posedge clk_sys);
        failures++;
        end_of_test();
    end
endmodule
